// *** logic/pwr_pkg.sv ***
// Constants, register map and mode encoding of the power mode supervisor.
// Assumes one 25 MHz clock and a plain strobe register port.
package pwr_pkg;
  // Clock period in ns
  localparam int CLK_NS = 40;
  // Register bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_MASK = 4'h2;
  localparam logic [3:0] OFS_INFO = 4'h3;
  localparam logic [3:0] OFS_THR = 4'h4;
  // Control register fields
  localparam int CTRL_DEEP = 0;
  localparam int CTRL_STANDBY = 1;
  localparam int CTRL_LPREG = 2;
  localparam int CTRL_EXTSEL = 3;
  localparam int CTRL_EXTEN = 4;
  localparam int CTRL_MONEN = 5;
  // Status and mask fields
  localparam int ST_CLKFAIL = 0;
  localparam int ST_SUPPLY = 1;
  localparam int ST_SBYWAKE = 2;
  localparam int ST_W = 3;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] THR_RST = 8'h80;
  // Regulator settle time before the fast RC is handed out
  localparam int REG_SETTLE_NS = 1000;
  localparam int REG_SETTLE_CYC = (REG_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // Missing external clock ticks for this long counts as failure
  localparam int EXT_LOSS_NS = 1000;
  localparam int EXT_LOSS_CYC = EXT_LOSS_NS / CLK_NS;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_STOP = 3'b010,
    MODE_REGUP = 3'b011,
    MODE_STANDBY = 3'b100
  } mode_t;
endpackage

// *** logic/ext_clock_watch.sv ***
// Watches tick pulses of the external fast oscillator for loss.
// Assumes the tick input is already synchronous to clk.
`timescale 1ns/100ps
module ext_clock_watch #(
  parameter int LOSS_CYC = pwr_pkg::EXT_LOSS_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic watch,
  input wire logic tick,
  output logic fail
);
  import pwr_pkg::*;

  initial begin
    if (LOSS_CYC < 2 || LOSS_CYC > 255) $error("LOSS_CYC out of range");
  end

  typedef struct packed {
    logic [7:0] quiet;
    logic fail;
  } watch_t;

  watch_t cur;
  watch_t next_cur;

  ////////////////////////////////////////////////////////////////////////
  // Count cycles without a tick while watched; one-cycle fail pulse
  always_comb begin
    next_cur = cur;
    next_cur.fail = 1'b0;
    if (!watch || tick) begin
      next_cur.quiet = 8'h00;
    end else if (cur.quiet == 8'(LOSS_CYC - 1)) begin
      // Restart so a dead clock reports once per window
      next_cur.quiet = 8'h00;
      next_cur.fail = 1'b1;
    end else begin
      next_cur.quiet = cur.quiet + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign fail = cur.fail;

  AST_FAIL_NEEDS_WATCH: assert property (@(posedge clk) disable iff (reset)
    fail |-> $past(watch) && !$past(tick)) else $error("spurious fail");
endmodule

// *** logic/supply_watch.sv ***
// Supply voltage monitor: compares a sampled level with a threshold.
// Assumes level is a digitised supply reading synchronous to clk.
`timescale 1ns/100ps
module supply_watch (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [7:0] level,
  input wire logic [7:0] threshold,
  output logic crossed
);
  import pwr_pkg::*;

  typedef struct packed {
    logic armed;
    logic below;
    logic crossed;
  } sup_t;

  sup_t cur;
  sup_t next_cur;

  ////////////////////////////////////////////////////////////////////////
  // Pulse on any change of side; the first enabled sample only arms
  always_comb begin
    next_cur = cur;
    next_cur.crossed = 1'b0;
    if (!enable) begin
      // Disabled monitor stays silent
      next_cur.armed = 1'b0;
    end else begin
      next_cur.armed = 1'b1;
      next_cur.below = level < threshold;
      next_cur.crossed = cur.armed && (cur.below != (level < threshold));
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign crossed = cur.crossed;

  AST_SUPPLY_SILENT: assert property (@(posedge clk) disable iff (reset)
    crossed |-> $past(enable, 2) && $past(enable)) else $error("idle monitor");
endmodule

// *** logic/power_supervisor.sv ***
// Power mode and system clock supervisor: Run, Sleep, Stop, Standby.
// Assumes all inputs synchronous to clk and a strobe register port.
//
// Contract
// - Regulator on after reset; low power in Stop
// - Sleep halts CPU clock only; any wake resumes
// - Stop gates core clocks, PLL, fast oscillators
// - Any enabled event line leaves Stop
// - Peripheral RC request raises regulator first
// - Standby powers off regulator and core domain
// - Standby exits on reset, watchdog, pin, calendar
// - Calendar and watchdog clocks never stop
// - Reset selects internal fast RC clock
// - External clock loss falls back, interrupts
// - Supply monitor silent until enabled, then interrupts
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module power_supervisor #(
  parameter int NUM_LINES = 16,
  parameter int NUM_MISC = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [pwr_pkg::ADDR_W-1:0] addr,
  input wire logic [pwr_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pwr_pkg::DATA_W-1:0] rdata,
  input wire logic wait_req,
  input wire logic irq_pending,
  input wire logic [NUM_LINES-1:0] external_event_lines,
  input wire logic [NUM_MISC-1:0] misc_wake,
  input wire logic calendar_event,
  input wire logic wakeup_pin,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic rc_request,
  input wire logic ext_tick,
  input wire logic [7:0] supply_level,
  output logic cpu_clk_en,
  output logic core_clk_en,
  output logic pll_en,
  output logic internal_fast_rc_en,
  output logic external_fast_oscillator_en,
  output logic regulator_on,
  output logic low_power_regulator_mode,
  output logic core_power_on,
  output logic sys_clk_ext,
  output logic rc_grant,
  output logic always_on_clk_en,
  output logic irq
);
  import pwr_pkg::*;

  initial begin
    if (NUM_LINES != 16) $error("NUM_LINES must be 16");
    if (NUM_MISC < 1 || NUM_MISC > 16) $error("NUM_MISC out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mode_t mode;           // Current operating mode
    logic [7:0] ctrl;      // Mode, clock and monitor control
    logic [7:0] thr;       // Supply monitor threshold
    logic [ST_W-1:0] stat; // Sticky event flags
    logic [ST_W-1:0] mask; // Interrupt enables
    logic [4:0] settle;    // Regulator settle countdown
    logic wakeup_pin_q;          // Wakeup pin last sample
    logic [7:0] rdata;
    logic cpu_clk_en;
    logic core_clk_en;
    logic pll_en;
    logic rc_en;
    logic ext_en;
    logic reg_on;
    logic reg_lp;
    logic core_pwr;
    logic ext_sel;
    logic rc_grant;
    logic aon;
    logic irq;
  } sup_state_t;

  sup_state_t cur;
  sup_state_t next_cur;

  logic clk_fail;       // One-cycle loss report
  logic supply_cross;   // One-cycle threshold crossing
  logic stop_wake;      // Any line able to leave Stop
  logic sby_wake;       // Any source able to leave Standby

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Watch only while the external oscillator is both running and used
  ext_clock_watch #(.LOSS_CYC(EXT_LOSS_CYC)) u_watch (
    .clk(clk),
    .reset(reset),
    .watch(cur.ext_sel && cur.ext_en),
    .tick(ext_tick),
    .fail(clk_fail)
  );

  supply_watch u_supply (
    .clk(clk),
    .reset(reset),
    .enable(cur.ctrl[CTRL_MONEN] && cur.core_pwr),
    .level(supply_level),
    .threshold(cur.thr),
    .crossed(supply_cross)
  );

  // Monitor output is itself one of the Stop wake lines
  assign stop_wake = (|external_event_lines) || (|misc_wake) ||
    calendar_event || supply_cross;
  // Only these four sources reach the standby circuitry
  assign sby_wake = !external_reset_pin_n || watchdog_reset ||
    (wakeup_pin && !cur.wakeup_pin_q) || calendar_event;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_cur = cur;
    next_cur.wakeup_pin_q = wakeup_pin;
    next_cur.rdata = 8'h00;

    // Register writes
    if (wr) begin
      unique case (addr)
        OFS_CTRL: next_cur.ctrl = wdata;
        OFS_MASK: next_cur.mask = wdata[ST_W-1:0];
        OFS_THR: next_cur.thr = wdata;
        // Write one to clear
        OFS_STAT: next_cur.stat = cur.stat & ~wdata[ST_W-1:0];
        default: ;
      endcase
    end
    // Ext clock cannot be chosen while its oscillator is off
    if (!next_cur.ctrl[CTRL_EXTEN]) begin
      next_cur.ctrl[CTRL_EXTSEL] = 1'b0;
    end

    // Events set after the clear so a same-cycle event wins
    if (clk_fail) begin
      next_cur.ctrl[CTRL_EXTSEL] = 1'b0;
      next_cur.stat[ST_CLKFAIL] = 1'b1;
    end
    if (supply_cross) begin
      next_cur.stat[ST_SUPPLY] = 1'b1;
    end

    // Read data for the next cycle only
    if (rd) begin
      unique case (addr)
        OFS_CTRL: next_cur.rdata = cur.ctrl;
        OFS_STAT: next_cur.rdata = {5'h00, cur.stat};
        OFS_MASK: next_cur.rdata = {5'h00, cur.mask};
        OFS_INFO: next_cur.rdata = {cur.rc_grant, cur.reg_lp, cur.ext_sel,
          2'h0, cur.mode};
        OFS_THR: next_cur.rdata = cur.thr;
        default: next_cur.rdata = 8'h00;
      endcase
    end

    // Mode sequencing
    next_cur.settle = (cur.settle != 5'h00) ? cur.settle - 5'h01 : 5'h00;
    unique case (cur.mode)
      MODE_RUN: begin
        // Entry only through a wait instruction
        if (wait_req) begin
          if (!cur.ctrl[CTRL_DEEP]) begin
            next_cur.mode = MODE_SLEEP;
          end else if (cur.ctrl[CTRL_STANDBY]) begin
            next_cur.mode = MODE_STANDBY;
          end else begin
            next_cur.mode = MODE_STOP;
          end
        end
      end
      MODE_SLEEP: begin
        // Peripherals keep running; any wake resumes the core
        if (irq_pending || stop_wake || cur.irq) begin
          next_cur.mode = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (stop_wake) begin
          next_cur.mode = MODE_RUN;
        end else if (rc_request && cur.reg_lp) begin
          // Regulator back to main mode before the clock goes out
          next_cur.mode = MODE_REGUP;
          next_cur.settle = 5'(REG_SETTLE_CYC);
        end
      end
      MODE_REGUP: begin
        if (stop_wake) begin
          next_cur.mode = MODE_RUN;
        end else if (!rc_request && cur.settle == 5'h00) begin
          next_cur.mode = MODE_STOP;
        end
      end
      MODE_STANDBY: begin
        if (sby_wake) begin
          // Standby loses all state but the wake flag
          next_cur.mode = MODE_RUN;
          next_cur.ctrl = CTRL_RST;
          next_cur.thr = THR_RST;
          next_cur.mask = '0;
          next_cur.stat = '0;
          next_cur.stat[ST_SBYWAKE] = 1'b1;
        end
      end
      default: next_cur.mode = MODE_RUN;
    endcase

    // Outputs follow the next mode so they change with it
    next_cur.cpu_clk_en = next_cur.mode == MODE_RUN;
    next_cur.core_clk_en = next_cur.mode inside {MODE_RUN, MODE_SLEEP};
    next_cur.pll_en = next_cur.core_clk_en;
    next_cur.ext_en = next_cur.core_clk_en && next_cur.ctrl[CTRL_EXTEN];
    next_cur.reg_on = next_cur.mode != MODE_STANDBY;
    next_cur.core_pwr = next_cur.reg_on;
    // Low power regulator only while fully stopped
    next_cur.reg_lp = (next_cur.mode == MODE_STOP) &&
      next_cur.ctrl[CTRL_LPREG];
    // Judged on the next count: at the Stop to RegUp edge the old count is
    // still zero, and granting there would hand out the clock unsettled
    next_cur.rc_grant = rc_request && ((next_cur.mode == MODE_STOP &&
      !next_cur.reg_lp) || (next_cur.mode == MODE_REGUP &&
      next_cur.settle == 5'h00));
    next_cur.rc_en = next_cur.core_clk_en || next_cur.rc_grant;
    next_cur.ext_sel = next_cur.ctrl[CTRL_EXTSEL] && next_cur.ext_en;
    next_cur.aon = 1'b1;
    next_cur.irq = |(next_cur.stat & next_cur.mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset comes up in Run on the internal RC

  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
      cur.mode <= MODE_RUN;
      cur.ctrl <= CTRL_RST;
      cur.thr <= THR_RST;
      cur.cpu_clk_en <= 1'b1;
      cur.core_clk_en <= 1'b1;
      cur.pll_en <= 1'b1;
      cur.rc_en <= 1'b1;
      cur.reg_on <= 1'b1;
      cur.core_pwr <= 1'b1;
      cur.aon <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata = cur.rdata;
  assign cpu_clk_en = cur.cpu_clk_en;
  assign core_clk_en = cur.core_clk_en;
  assign pll_en = cur.pll_en;
  assign internal_fast_rc_en = cur.rc_en;
  assign external_fast_oscillator_en = cur.ext_en;
  assign regulator_on = cur.reg_on;
  assign low_power_regulator_mode = cur.reg_lp;
  assign core_power_on = cur.core_pwr;
  assign sys_clk_ext = cur.ext_sel;
  assign rc_grant = cur.rc_grant;
  assign always_on_clk_en = cur.aon;
  assign irq = cur.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_REG_LP_ONLY_STOP: assert property (
    low_power_regulator_mode |-> cur.mode == MODE_STOP && regulator_on)
    else $error("low power regulator outside Stop");
  AST_SLEEP_CLOCKS: assert property (
    cur.mode == MODE_SLEEP |-> !cpu_clk_en && core_clk_en && pll_en)
    else $error("sleep clock gating wrong");
  AST_STOP_GATES: assert property (
    cur.mode == MODE_STOP |-> !core_clk_en && !pll_en &&
    !external_fast_oscillator_en && (internal_fast_rc_en == rc_grant))
    else $error("stop left a clock running");
  AST_STOP_WAKE: assert property (
    cur.mode == MODE_STOP && (|external_event_lines) |=>
    cur.mode == MODE_RUN && cpu_clk_en)
    else $error("event line did not leave stop");
  AST_GRANT_AFTER_MAIN: assert property (
    rc_grant |-> !low_power_regulator_mode && $past(regulator_on) &&
    !$past(low_power_regulator_mode))
    else $error("clock granted on low power regulator");
  AST_STANDBY_OFF: assert property (
    cur.mode == MODE_STANDBY |-> !regulator_on && !core_power_on &&
    !internal_fast_rc_en && !pll_en)
    else $error("standby left power on");
  AST_STANDBY_EXIT: assert property (
    $past(cur.mode) == MODE_STANDBY && cur.mode == MODE_RUN |->
    $past(!external_reset_pin_n || watchdog_reset || calendar_event ||
    (wakeup_pin && !cur.wakeup_pin_q)) && cur.stat[ST_SBYWAKE])
    else $error("standby left without cause");
  AST_ALWAYS_ON: assert property (always_on_clk_en[*2])
    else $error("calendar clock stopped");
  AST_FALLBACK: assert property (
    clk_fail |=> !sys_clk_ext && cur.stat[ST_CLKFAIL] &&
    (irq || !cur.mask[ST_CLKFAIL]))
    else $error("no fallback on clock loss");
  AST_MONITOR_IRQ: assert property (
    supply_cross && cur.mask[ST_SUPPLY] && !wr |=> cur.stat[ST_SUPPLY] && irq)
    else $error("supply crossing lost");
  AST_WAIT_ENTRY: assert property (
    $past(cur.mode) == MODE_RUN && cur.mode != MODE_RUN |-> $past(wait_req))
    else $error("low power mode without wait");
endmodule

// *** sim/ext_osc_model.sv ***
// Far-side model: the external fast oscillator feeding activity ticks.
// Assumes clk is the supervisor clock; each tick stands one cycle.
`timescale 1ns/100ps
module ext_osc_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic alive,
  output logic tick
);
  // Divider: one tick every fourth cycle, well inside the loss window
  logic [1:0] phase;

  ////////////////////////////////////////////////////////////////////////
  // A dead crystal gives no ticks even while enabled, as in real life
  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      phase <= 2'h0;
      tick <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      tick <= alive && (phase == 2'h3);
    end
  end
endmodule

// *** sim/power_supervisor_test.sv ***
// Self-checking bench of the power mode supervisor.
// Assumes a 25 MHz clock and the strobe register port of the design.
`timescale 1ns/100ps
module power_supervisor_test;
  import pwr_pkg::*;
  logic clk, reset, wr, rd, wait_req, rc_request, alive, tick;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [7:0] supply_level;
  // Wake stimuli: lines, misc, calendar, irq, pin low, watchdog, wake pin
  logic [28:0] stim;
  logic cpu_clk_en, core_clk_en, pll_en, internal_fast_rc_en;
  logic external_fast_oscillator_en, regulator_on, low_power_regulator_mode;
  logic core_power_on, sys_clk_ext, rc_grant, always_on_clk_en, irq;
  int err_total = 0;
  int cmp_count = 0;
  // Standby exit causes: calendar, reset pin, watchdog, wake pin
  int src[4] = '{24, 26, 27, 28};

  power_supervisor power_supervisor_i (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .wait_req(wait_req), .irq_pending(stim[25]),
    .external_event_lines(stim[15:0]), .misc_wake(stim[23:16]),
    .calendar_event(stim[24]), .wakeup_pin(stim[28]),
    .external_reset_pin_n(!stim[26]), .watchdog_reset(stim[27]),
    .rc_request(rc_request), .ext_tick(tick), .supply_level(supply_level),
    .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en), .pll_en(pll_en),
    .internal_fast_rc_en(internal_fast_rc_en),
    .external_fast_oscillator_en(external_fast_oscillator_en),
    .regulator_on(regulator_on),
    .low_power_regulator_mode(low_power_regulator_mode),
    .core_power_on(core_power_on), .sys_clk_ext(sys_clk_ext),
    .rc_grant(rc_grant), .always_on_clk_en(always_on_clk_en), .irq(irq)
  );

  ext_osc_model ext_osc_model_i (
    .clk(clk), .reset(reset), .enable(external_fast_oscillator_en),
    .alive(alive), .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict; the only place the run ends
  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Byte compare
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single flag compare
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask

  // Register write: one strobe cycle
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Register read: data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask

  // Wait instruction pulse, outputs looked at once it has landed
  task automatic wait_pulse();
    @(posedge clk);
    wait_req <= 1'b1;
    @(posedge clk);
    wait_req <= 1'b0;
    #1;
  endtask

  // One-cycle wake stimulus
  task automatic kick(input logic [28:0] w);
    @(posedge clk);
    stim <= w;
    @(posedge clk);
    stim <= '0;
    #1;
  endtask

  // Bounded wait for grant (0) or clock source (1) to reach a level
  task automatic wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (((k == 0) ? rc_grant : sys_clk_ext) !== v && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 200) begin
      chk("wait limit", 8'h01, 8'h00);
      end_of_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    {wr, rd, wait_req, rc_request} = '0;
    addr = '0;
    wdata = '0;
    stim = '0;
    supply_level = 8'hFF;
    alive = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chkb("regulator_on", 1'b1, regulator_on);
    chkb("lp_mode", 1'b0, low_power_regulator_mode);
    chkb("sys_clk_ext", 1'b0, sys_clk_ext);
    chkb("rc_en", 1'b1, internal_fast_rc_en);
    reg_rd(OFS_CTRL, 8'h00);
    reg_rd(OFS_THR, 8'h80);
    reg_rd(4'hF, 8'h00);
    // Sleep stops only the processor clock
    wait_pulse();
    chkb("cpu_clk_en", 1'b0, cpu_clk_en);
    chkb("core_clk_en", 1'b1, core_clk_en);
    kick(29'h1 << 25);
    chkb("cpu_clk_en", 1'b1, cpu_clk_en);
    // External clock loss falls back and interrupts
    reg_wr(OFS_MASK, 8'h01);
    reg_wr(OFS_CTRL, 8'h18);
    repeat (60) @(posedge clk);
    #1;
    chkb("sys_clk_ext", 1'b1, sys_clk_ext);
    chkb("irq", 1'b0, irq);
    @(posedge clk);
    alive <= 1'b0;
    repeat (18) @(posedge clk);
    #1;
    chkb("sys_clk_ext", 1'b1, sys_clk_ext);
    wait_for(1, 1'b0);
    chkb("irq", 1'b1, irq);
    reg_rd(OFS_STAT, 8'h01);
    reg_rd(OFS_CTRL, 8'h10);
    reg_wr(OFS_STAT, 8'h01);
    // Stop: each event, misc and calendar line in turn; the dead crystal stays enabled
    reg_wr(OFS_CTRL, 8'h11);
    for (int i = 0; i < 25; i++) begin
      wait_pulse();
      chkb("core_clk_en", 1'b0, core_clk_en);
      chkb("pll_en", 1'b0, pll_en);
      chkb("rc_en", 1'b0, internal_fast_rc_en);
      chkb("ext_en", 1'b0, external_fast_oscillator_en);
      chkb("always_on", 1'b1, always_on_clk_en);
      kick(29'h1 << i);
      chkb("core_clk_en", 1'b1, core_clk_en);
    end
    // Peripheral asks for the RC while the regulator is in low power
    reg_wr(OFS_CTRL, 8'h05);
    wait_pulse();
    chkb("lp_mode", 1'b1, low_power_regulator_mode);
    @(posedge clk);
    rc_request <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chkb("rc_grant", 1'b0, rc_grant);
    wait_for(0, 1'b1);
    chkb("lp_mode", 1'b0, low_power_regulator_mode);
    chkb("rc_en", 1'b1, internal_fast_rc_en);
    reg_rd(OFS_INFO, 8'h83);
    @(posedge clk);
    rc_request <= 1'b0;
    kick(29'h1);
    chkb("core_clk_en", 1'b1, core_clk_en);
    // Supply monitor silent until enabled
    reg_wr(OFS_CTRL, 8'h00);
    supply_level <= 8'h10;
    repeat (6) @(posedge clk);
    supply_level <= 8'hFF;
    reg_rd(OFS_STAT, 8'h00);
    reg_wr(OFS_MASK, 8'h02);
    reg_wr(OFS_CTRL, 8'h20);
    repeat (4) @(posedge clk);
    supply_level <= 8'h10;
    repeat (6) @(posedge clk);
    reg_rd(OFS_STAT, 8'h02);
    chkb("irq", 1'b1, irq);
    reg_wr(OFS_STAT, 8'h02);
    // Standby: a Stop wake line is refused, then each true exit
    for (int k = 0; k < 4; k++) begin
      reg_wr(OFS_CTRL, 8'h03);
      wait_pulse();
      chkb("regulator_on", 1'b0, regulator_on);
      chkb("core_power_on", 1'b0, core_power_on);
      chkb("pll_en", 1'b0, pll_en);
      chkb("always_on", 1'b1, always_on_clk_en);
      kick(29'h1);
      chkb("regulator_on", 1'b0, regulator_on);
      kick(29'h1 << src[k]);
      chkb("regulator_on", 1'b1, regulator_on);
      reg_rd(OFS_STAT, 8'h04);
      chkb("irq", 1'b0, irq);
      reg_wr(OFS_MASK, 8'h04);
      @(posedge clk);
      #1;
      chkb("irq", 1'b1, irq);
      reg_wr(OFS_STAT, 8'h04);
      @(posedge clk);
      #1;
      chkb("irq", 1'b0, irq);
    end
    end_of_test();
  end
endmodule
